//--- logic/dram_term_pkg.sv
// Constants, field layout and types for the on-die termination controller
`default_nettype none
package dram_term_pkg;

  // ----------------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------------
  localparam int          ADDR_W     = 4;
  localparam int          DATA_W     = 32;
  localparam logic [3:0]  OFS_TERM   = 4'h0;   // Termination value codes
  localparam logic [3:0]  OFS_LAT    = 4'h4;   // Latency and burst setup
  localparam logic [3:0]  OFS_STAT   = 4'h8;   // Live status
  localparam int          NOM_LSB    = 0;      // Nominal code, 3 bits
  localparam int          PARK_LSB   = 4;      // Parked code, 3 bits
  localparam int          WRC_LSB    = 8;      // Write code, 2 bits
  localparam int          CASWR_LSB  = 0;      // CAS write latency, 5 bits
  localparam int          ADDLAT_LSB = 8;      // Additive latency, 5 bits
  localparam int          PARLAT_LSB = 16;     // Parity latency, 3 bits
  localparam int          PRE2_BIT   = 20;     // 2-cycle write preamble
  localparam int          CRC_BIT    = 21;     // Write CRC enable
  localparam int          BURST_LSB  = 24;     // Burst mode, 2 bits
  localparam int          HOLDV_BIT  = 8;      // Status: pin hold violation
  localparam int          SYNC_BIT   = 9;      // Status: synchronous mode
  localparam int          RXEN_BIT   = 10;     // Status: pin receiver on
  localparam logic [31:0] TERM_RST   = 32'h0000_0000;
  localparam logic [31:0] LAT_RST    = 32'h0000_0009;

  // ----------------------------------------------------------------------
  // Burst modes and timing figures, all in clock cycles
  // ----------------------------------------------------------------------
  localparam logic [1:0]  BURST_FULL = 2'h0;   // Fixed 8-beat
  localparam logic [1:0]  BURST_OTF  = 2'h1;   // Chosen per command
  localparam logic [1:0]  BURST_CHOP = 2'h2;   // Fixed 4-beat
  localparam int          HIST_DEPTH = 64;
  localparam logic [6:0]  LAT_X1     = 7'h02;  // 1-cycle preamble offset
  localparam logic [6:0]  LAT_X2     = 7'h03;  // 2-cycle preamble offset
  localparam logic [6:0]  HALF_CHOP  = 7'h02;  // Four beats over two edges
  localparam logic [6:0]  HALF_FULL  = 7'h04;  // Eight beats
  localparam logic [6:0]  CWN4_P1    = 7'h04;  // 1T, CRC off
  localparam logic [6:0]  CWN4_P2    = 7'h05;  // 2T, CRC off
  localparam logic [6:0]  CWN4_C1    = 7'h07;  // 1T, CRC on
  localparam logic [6:0]  CWN4_C2    = 7'h08;  // 2T, CRC on
  localparam logic [6:0]  CWN8_P1    = 7'h06;
  localparam logic [6:0]  CWN8_P2    = 7'h07;
  localparam logic [6:0]  CWN8_C1    = 7'h07;
  localparam logic [6:0]  CWN8_C2    = 7'h08;
  localparam logic [6:0]  HOLD_CHOP  = 7'h04;  // Pin hold, 4-beat
  localparam logic [6:0]  HOLD_FULL  = 7'h06;  // Pin hold, 8-beat

  // ----------------------------------------------------------------------
  // Termination state, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_HIZ   = 5'b00001,
    ST_PARK  = 5'b00010,
    ST_NOM   = 5'b00100,
    ST_WR    = 5'b01000,
    ST_DRIVE = 5'b10000
  } term_state_e;

  // Code to effective resistance in ohms; zero means off
  localparam logic [7:0] OHMS_NP [8] = '{8'h00, 8'h3C, 8'h78, 8'h28,
                                         8'hF0, 8'h30, 8'h50, 8'h22};
  localparam logic [7:0] OHMS_WR [4] = '{8'h00, 8'h78, 8'hF0, 8'h50};

endpackage
`default_nettype wire

//--- logic/dram_termination_control.sv
// On-die termination state selection for the data-group pins
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - Enabled write termination overrides pin, nominal and parked in window
// R2 - Read disables termination and drives, regardless of pin and settings
// R3 - Idle: nominal if enabled and pin high, else parked, else high-Z
// R4 - Nominal disabled powers off the termination pin receiver
// R5 - Supported values 240, 120, 80, 60, 48, 40, 34 ohms by code
// R6 - Synchronous timing whenever the delay-locked loop is locked
// R7 - Nominal follows sampled pin after turn-on and turn-off latencies
// R8 - Direct latencies are write latency minus 2, or 3 with long preamble
// R9 - Additive and parity latency included in every latency
// R10 - Read turn-off latency is write latency minus 2 or 3
// R11 - Parked returns after read turn-off plus 4/5 chop, 6/7 full
// R12 - Controller holds the pin high for the minimum hold time
// R13 - Hold counted from pin first high, or from a write command
// R14 - Never terminate while driving; restore only after postamble
// R15 - Write termination enabled when either write code bit is set
// R16 - Nominal, parked and write values from their mode-register fields
// R17 - Without commands nominal follows pin, parked while pin low
// R18 - Any write selects write termination a select latency later
// R19 - Write termination deselected after chop or full deselect latency
// R20 - Deselect latencies adjusted for CRC and long preamble
// R21 - Write select latency is write latency minus 2 or 3
// R22 - Read off window lasts burst/2 + X + Y cycles
// R23 - Self-refresh forces high-Z whatever the settings
// R24 - Pin ignored when nominal disabled and during self-refresh
// R25 - Back-to-back writes keep write termination continuous
module dram_termination_control (
  input  wire logic        clock,        // 200 MHz device clock
  input  wire logic        rst,          // Synchronous reset, active high
  input  wire logic [3:0]  regAddr,      // Register byte address
  input  wire logic [31:0] regWrData,    // Register write data
  input  wire logic        regWrite,     // Write strobe
  input  wire logic        regRead,      // Read strobe
  output logic      [31:0] regRdData,    // Read data, cycle after strobe
  input  wire logic        odtPin,       // Termination control pin
  input  wire logic        cmdWrite,     // Registered write command
  input  wire logic        cmdRead,      // Registered read command
  input  wire logic        cmdChopOtf,   // On-the-fly 4-beat select
  input  wire logic        selfRefresh,  // Device in self-refresh
  input  wire logic        dllLocked,    // Delay-locked loop locked
  output logic      [4:0]  termState,    // One-hot termination state
  output logic      [7:0]  rttOhms,      // Effective resistance, 0 = off
  output logic             driveEnable,  // Data drivers on for a read
  output logic             odtRxEnable   // Pin receiver powered
);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [31:0] termCfg_r;
  logic [31:0] latCfg_r;
  logic        holdViol_r;
  logic        holdSet;
  logic [2:0]  nomCode;
  logic [2:0]  parkCode;
  logic [1:0]  wrCode;
  logic        nomEn;
  logic        parkEn;
  logic        wrEn;
  logic        pre2;
  logic        crcEn;
  logic [1:0]  burstMode;
  logic [6:0]  wrLat;
  logic [6:0]  baseLat;
  logic [6:0]  cwnAdd4;
  logic [6:0]  cwnAdd8;
  logic [6:0]  readDur4;
  logic [6:0]  readDur8;
  logic [6:0]  holdNeed;

  // Fields feeding the selection logic
  assign nomCode   = termCfg_r[dram_term_pkg::NOM_LSB +: 3];    // R16
  assign parkCode  = termCfg_r[dram_term_pkg::PARK_LSB +: 3];   // R16
  assign wrCode    = termCfg_r[dram_term_pkg::WRC_LSB +: 2];    // R16
  assign nomEn     = |nomCode;
  assign parkEn    = |parkCode;
  assign wrEn      = |wrCode;                                   // R15
  assign pre2      = latCfg_r[dram_term_pkg::PRE2_BIT];
  assign crcEn     = latCfg_r[dram_term_pkg::CRC_BIT];
  assign burstMode = latCfg_r[dram_term_pkg::BURST_LSB +: 2];

  // Write latency includes additive and parity latency every time
  assign wrLat = 7'(latCfg_r[dram_term_pkg::CASWR_LSB +: 5])
               + 7'(latCfg_r[dram_term_pkg::ADDLAT_LSB +: 5])
               + 7'(latCfg_r[dram_term_pkg::PARLAT_LSB +: 3]);  // R9
  // One figure serves direct on/off, write select and read turn-off
  assign baseLat = wrLat - (pre2 ? dram_term_pkg::LAT_X2
                                 : dram_term_pkg::LAT_X1);  // R8 R10 R21

  // Deselect offsets from the select point, by CRC and preamble
  always_comb begin
    if (crcEn) begin
      cwnAdd4 = pre2 ? dram_term_pkg::CWN4_C2 : dram_term_pkg::CWN4_C1;
      cwnAdd8 = pre2 ? dram_term_pkg::CWN8_C2 : dram_term_pkg::CWN8_C1;
    end else begin
      cwnAdd4 = pre2 ? dram_term_pkg::CWN4_P2 : dram_term_pkg::CWN4_P1;
      cwnAdd8 = pre2 ? dram_term_pkg::CWN8_P2 : dram_term_pkg::CWN8_P1;
    end  // R20
  end

  // Read off window: burst/2 + X + Y, X by preamble, Y by CRC
  assign readDur4 = dram_term_pkg::HALF_CHOP
                  + (pre2 ? dram_term_pkg::LAT_X2 : dram_term_pkg::LAT_X1)
                  + {6'h00, crcEn};                         // R11 R22
  assign readDur8 = dram_term_pkg::HALF_FULL
                  + (pre2 ? dram_term_pkg::LAT_X2 : dram_term_pkg::LAT_X1)
                  + {6'h00, crcEn};                         // R11 R22

  // ----------------------------------------------------------------------
  // Command and pin history
  // ----------------------------------------------------------------------
  localparam int HD = dram_term_pkg::HIST_DEPTH;
  logic [HD-1:0] wrHist_r;
  logic [HD-1:0] wrChop_r;
  logic [HD-1:0] rdHist_r;
  logic [HD-1:0] rdChop_r;
  logic [HD-1:0] pinHist_r;
  logic          chopNow;
  logic          pinEff;

  // A fixed 4-beat mode, or the on-the-fly select, makes a chop burst
  assign chopNow = (burstMode == dram_term_pkg::BURST_CHOP)
                || ((burstMode == dram_term_pkg::BURST_OTF) && cmdChopOtf);
  // Receiver is off when nominal is disabled or in self-refresh
  assign pinEff  = odtPin & nomEn & ~selfRefresh;  // R4 R24

  // Bit i holds the event taken i+1 edges before the next update
  always_ff @(posedge clock) begin
    if (rst) begin
      wrHist_r  <= '0;
      wrChop_r  <= '0;
      rdHist_r  <= '0;
      rdChop_r  <= '0;
      pinHist_r <= '0;
    end else begin
      wrHist_r  <= {wrHist_r[HD-2:0], cmdWrite};   // R18
      wrChop_r  <= {wrChop_r[HD-2:0], chopNow};
      rdHist_r  <= {rdHist_r[HD-2:0], cmdRead};
      rdChop_r  <= {rdChop_r[HD-2:0], chopNow};
      pinHist_r <= {pinHist_r[HD-2:0], pinEff};    // R7
    end
  end

  // Windows per history entry; union keeps back-to-back writes seamless
  logic [HD-1:0] wrHit;
  logic [HD-1:0] rdHit;
  for (genvar i = 0; i < HD; i++) begin : g_win
    localparam logic [6:0] AGE = 7'(i + 1);
    assign wrHit[i] = wrHist_r[i] && (AGE >= baseLat)
                   && (AGE < baseLat + (wrChop_r[i] ? cwnAdd4
                                                    : cwnAdd8)); // R19 R25
    assign rdHit[i] = rdHist_r[i] && (AGE >= baseLat)
                   && (AGE < baseLat + (rdChop_r[i] ? readDur4
                                                    : readDur8)); // R2 R14
  end

  logic readOff;
  logic writeOn;
  logic nomOn;
  assign readOff = |rdHit;
  assign writeOn = |wrHit;
  // Locked: pin seen through the direct latency; unlocked: seen one cycle later
  assign nomOn = dllLocked ? pinHist_r[6'(baseLat - 7'h01)]
                           : pinHist_r[0];              // R6 R7 R17

  // ----------------------------------------------------------------------
  // Termination selection, priority self-refresh > read > write > nominal > parked
  // ----------------------------------------------------------------------
  dram_term_pkg::term_state_e stateNxt;
  logic [7:0]                 ohmsNxt;

  always_comb begin
    if (selfRefresh) begin
      stateNxt = dram_term_pkg::ST_HIZ;                 // R23
    end else if (readOff) begin
      stateNxt = dram_term_pkg::ST_DRIVE;               // R2 R14
    end else if (writeOn && wrEn) begin
      stateNxt = dram_term_pkg::ST_WR;                  // R1
    end else if (nomOn && nomEn) begin
      stateNxt = dram_term_pkg::ST_NOM;                 // R3 R17
    end else if (parkEn) begin
      stateNxt = dram_term_pkg::ST_PARK;                // R3 R17
    end else begin
      stateNxt = dram_term_pkg::ST_HIZ;                 // R3
    end
    case (stateNxt)
      dram_term_pkg::ST_WR:   ohmsNxt = dram_term_pkg::OHMS_WR[wrCode];
      dram_term_pkg::ST_NOM:  ohmsNxt = dram_term_pkg::OHMS_NP[nomCode];
      dram_term_pkg::ST_PARK: ohmsNxt = dram_term_pkg::OHMS_NP[parkCode];
      default:                ohmsNxt = 8'h00;          // R5
    endcase
  end

  // Outputs are registered so the pads see glitch-free selects
  always_ff @(posedge clock) begin
    if (rst) begin
      termState   <= dram_term_pkg::ST_HIZ;
      rttOhms     <= 8'h00;
      driveEnable <= 1'b0;
      odtRxEnable <= 1'b0;
    end else begin
      termState   <= stateNxt;
      rttOhms     <= ohmsNxt;
      driveEnable <= (stateNxt == dram_term_pkg::ST_DRIVE);  // R14
      odtRxEnable <= nomEn & ~selfRefresh;                   // R4
    end
  end

  // ----------------------------------------------------------------------
  // Pin hold check
  // ----------------------------------------------------------------------
  logic       pinPrev_r;
  logic       holding_r;
  logic [6:0] holdCnt_r;

  // The controller owns the hold; we only flag a short one for software
  assign holdNeed = ((burstMode == dram_term_pkg::BURST_CHOP)
                     ? dram_term_pkg::HOLD_CHOP : dram_term_pkg::HOLD_FULL)
                  + {6'h00, crcEn} + {6'h00, pre2};              // R12
  assign holdSet  = holding_r && !pinEff && (holdCnt_r < holdNeed);

  // Count restarts on the first registered high or a write under pin high
  always_ff @(posedge clock) begin
    if (rst) begin
      pinPrev_r <= 1'b0;
      holding_r <= 1'b0;
      holdCnt_r <= 7'h00;
    end else begin
      pinPrev_r <= pinEff;
      if (pinEff && (!pinPrev_r || cmdWrite)) begin
        holding_r <= 1'b1;                                       // R13
        holdCnt_r <= 7'h01;
      end else if (holding_r && !pinEff) begin
        holding_r <= 1'b0;
      end else if (holding_r && holdCnt_r != 7'h7F) begin
        holdCnt_r <= holdCnt_r + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  // Writes; a new violation beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      termCfg_r  <= dram_term_pkg::TERM_RST;
      latCfg_r   <= dram_term_pkg::LAT_RST;
      holdViol_r <= 1'b0;
    end else begin
      if (regWrite && regAddr == dram_term_pkg::OFS_TERM) begin
        termCfg_r <= regWrData;
      end else if (regWrite && regAddr == dram_term_pkg::OFS_LAT) begin
        latCfg_r <= regWrData;
      end
      if (holdSet) begin
        holdViol_r <= 1'b1;
      end else if (regWrite && regAddr == dram_term_pkg::OFS_STAT
                   && regWrData[dram_term_pkg::HOLDV_BIT]) begin
        holdViol_r <= 1'b0;
      end
    end
  end

  // Reads answer one cycle later; unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRead && regAddr == dram_term_pkg::OFS_TERM) begin
      regRdData <= termCfg_r;
    end else if (regRead && regAddr == dram_term_pkg::OFS_LAT) begin
      regRdData <= latCfg_r;
    end else if (regRead && regAddr == dram_term_pkg::OFS_STAT) begin
      regRdData <= {21'h0, odtRxEnable, dllLocked, holdViol_r,
                    3'h0, termState};
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_selfref_hiz: assert property (selfRefresh |=>
    termState == dram_term_pkg::ST_HIZ && rttOhms == 8'h00) // R23
    else $error("self-refresh did not force high-Z");
  a_read_drives: assert property (!selfRefresh && readOff |=>
    termState == dram_term_pkg::ST_DRIVE && driveEnable) // R2
    else $error("read window not driving");
  a_write_wins: assert property
    (!selfRefresh && !readOff && writeOn && wrEn && nomOn |=>
     termState == dram_term_pkg::ST_WR) // R1
    else $error("write termination lost to nominal");
  a_no_term_drive: assert property (driveEnable |-> rttOhms == 8'h00) // R14
    else $error("terminating while driving");
  a_rx_powered: assert property (odtRxEnable |-> $past(nomEn)) // R4
    else $error("pin receiver on with nominal disabled");
  a_nom_enabled: assert property (termState == dram_term_pkg::ST_NOM
    |-> $past(nomEn) && $past(nomOn)) // R3
    else $error("nominal without enable or pin");
  a_nom_latency: assert property (dllLocked && $stable(latCfg_r)
    && pinHist_r[6'(baseLat - 7'h01)] && nomEn && !selfRefresh
    && !readOff && !writeOn |=> termState == dram_term_pkg::ST_NOM) // R7
    else $error("nominal not on after turn-on latency");
  a_hold_flag: assert property (holdSet |=> holdViol_r) // R13
    else $error("short pin hold not flagged");
  a_read_answer: assert property (regRead
    && regAddr == dram_term_pkg::OFS_LAT |=> regRdData == $past(latCfg_r))
    else $error("read data not from latency register");
  // Idle fall-back: parked value when nothing else claims the pads
  a_park_idle: assert property ( // R3
    !selfRefresh && !readOff && !(writeOn && wrEn) && !(nomOn && nomEn)
    && parkEn |=> termState == dram_term_pkg::ST_PARK)
    else $error("parked termination not selected");
  a_no_wr_term: assert property ( // R15
    !wrEn |=> termState != dram_term_pkg::ST_WR)
    else $error("write termination with zero write code");
  a_pin_ignored: assert property ( // R24
    !nomEn |=> termState != dram_term_pkg::ST_NOM)
    else $error("nominal termination while disabled");
  a_rx_selfref: assert property ( // R24
    selfRefresh |=> !odtRxEnable)
    else $error("pin receiver on in self-refresh");
  a_hold_start: assert property ( // R13
    pinEff && !pinPrev_r |=> holding_r && holdCnt_r == 7'h01)
    else $error("pin hold count did not restart");

  c_read_window: cover property (cmdRead ##1 !readOff [*3] ##1 readOff);
  c_write_term: cover property (termState == dram_term_pkg::ST_WR);
  c_nom_to_write: cover property (termState == dram_term_pkg::ST_NOM
    ##1 termState == dram_term_pkg::ST_WR);
  c_hold_viol: cover property (holdSet);

endmodule

`default_nettype wire

//--- verif/odt_host_model.sv
// Controller model driving the commands and the termination pin
`timescale 1ns/1ps
`default_nettype none
module odt_host_model (
  input  wire logic       clock,      // Device clock
  input  wire logic       rst,        // Sync reset
  input  wire logic       wantPin,    // Raise the pin
  input  wire logic       wantWrite,  // Issue a write
  input  wire logic       wantRead,   // Issue a read
  input  wire logic       wantChop,   // Mark 4-beat
  input  wire logic       shortPin,   // Cut the hold short
  input  wire logic [3:0] holdNeed,   // Minimum high samples
  output logic            odtPin,     // Termination pin
  output logic            cmdWrite,   // Write command
  output logic            cmdRead,    // Read command
  output logic            cmdChopOtf  // 4-beat marker
);
  logic [3:0] holdCnt_r;  // Samples the pin has stood high
  logic       keepUp;     // Hold not yet met

  // A raised pin stays up for the whole hold; only a scenario that
  // wants to provoke the device's hold flag may cut it short
  assign keepUp = odtPin & ~shortPin & (holdCnt_r < holdNeed);
  always_ff @(posedge clock) begin
    if (rst) begin
      odtPin    <= 1'b0;
      holdCnt_r <= 4'h0;
    end else begin
      odtPin    <= wantPin | keepUp;
      holdCnt_r <= odtPin ? holdCnt_r + 4'h1 : 4'h1;
    end
  end

  // Commands are the requests registered one cycle later, for as long as held; the chop mark rides along
  always_ff @(posedge clock) begin
    if (rst) begin
      cmdWrite   <= 1'b0;
      cmdRead    <= 1'b0;
      cmdChopOtf <= 1'b0;
    end else begin
      cmdWrite   <= wantWrite;
      cmdRead    <= wantRead;
      cmdChopOtf <= wantChop;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_dram_termination_control.sv
// Self-checking bench for the termination controller
`timescale 1ns/1ps
`default_nettype none
module tb_dram_termination_control;
  logic        clock, rst, regWrite, regRead, odtPin, cmdWrite, cmdRead;
  logic        cmdChopOtf, selfRefresh, dllLocked, driveEnable;
  logic        odtRxEnable, wantPin, wantWrite, wantRead, wantChop;
  logic        shortPin;
  logic [3:0]  regAddr, holdNeed;
  logic [31:0] regWrData, regRdData;
  logic [4:0]  termState;
  logic [7:0]  rttOhms;
  int          n_mismatch, check_count;
  localparam logic [4:0] HIZ = 5'h01, PRK = 5'h02, NOM = 5'h04;
  localparam logic [4:0] WRT = 5'h08, DRV = 5'h10;
  typedef struct packed {
    logic [7:0] term; logic pin; logic [4:0] st; logic [7:0] ohm; logic rx;
  } idle_s;
  typedef struct packed {
    logic [31:0] lat; logic chop; logic [3:0] hold, lt, wr, rd;
  } cfg_s;
  // Idle rows: codes {park,nom}, pin level, state, ohms, receiver on
  localparam idle_s IDLE [9] = '{
    '{8'h21, 1'b1, NOM, 8'h3C, 1'b1}, '{8'h21, 1'b0, PRK, 8'h78, 1'b1},
    '{8'h40, 1'b1, PRK, 8'hF0, 1'b0}, '{8'h03, 1'b1, NOM, 8'h28, 1'b1},
    '{8'h03, 1'b0, HIZ, 8'h00, 1'b1}, '{8'h00, 1'b1, HIZ, 8'h00, 1'b0},
    '{8'h65, 1'b1, NOM, 8'h30, 1'b1}, '{8'h67, 1'b0, PRK, 8'h50, 1'b1},
    '{8'h07, 1'b1, NOM, 8'h22, 1'b1}};
  // Latency rows: setup word, chop, hold, latency, write and read spans
  localparam cfg_s CFG [5] = '{
    '{32'h0000_0009, 1'b0, 4'h6, 4'h7, 4'h6, 4'h6},
    '{32'h0212_030A, 1'b0, 4'h5, 4'hC, 4'h5, 4'h5},
    '{32'h0220_0009, 1'b0, 4'h5, 4'h7, 4'h7, 4'h5},
    '{32'h0130_000C, 1'b0, 4'h8, 4'h9, 4'h8, 4'h8},
    '{32'h0100_000B, 1'b1, 4'h6, 4'h9, 4'h4, 4'h4}};

  dram_termination_control u_dut (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .odtPin(odtPin), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdChopOtf(cmdChopOtf), .selfRefresh(selfRefresh),
    .dllLocked(dllLocked), .termState(termState), .rttOhms(rttOhms),
    .driveEnable(driveEnable), .odtRxEnable(odtRxEnable));
  odt_host_model u_host (
    .clock(clock), .rst(rst), .wantPin(wantPin), .wantWrite(wantWrite),
    .wantRead(wantRead), .wantChop(wantChop), .shortPin(shortPin),
    .holdNeed(holdNeed), .odtPin(odtPin), .cmdWrite(cmdWrite),
    .cmdRead(cmdRead), .cmdChopOtf(cmdChopOtf));

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Register bus: one-cycle strobes, read data only in the next cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clock);
    regWrite  <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    chk("regRdData", e, regRdData);
    @(negedge clock);
    chk("regRdIdle", 32'h0, regRdData);
  endtask

  // Issue a request (again g2 cycles on if g2 > 0) and time the state
  // window it opens; sampling on the falling edge avoids races
  task automatic win(input int sel, input logic pw, input int g2,
                     input logic [4:0] tg, input int eL, input int eD,
                     input logic [7:0] eO);
    int t0, ts, te;
    logic [7:0] oh;
    logic go, trg, de;
    t0 = -1;
    ts = -1;
    te = -1;
    for (int t = 0; t < 200 && te < 0; t++) begin
      @(posedge clock);
      go = (t == 0) || (t == g2);
      wantPin   <= go && (pw || sel == 0);
      wantWrite <= go && sel == 1;
      wantRead  <= go && sel == 2;
      @(negedge clock);
      trg = (sel == 0) ? odtPin : ((sel == 1) ? cmdWrite : cmdRead);
      if (t0 < 0 && trg === 1'b1) t0 = t + 1;
      if (t0 >= 0 && ts < 0 && termState === tg) begin
        ts = t;
        oh = rttOhms;
        de = driveEnable;
      end else if (ts >= 0 && termState !== tg) begin
        te = t;
      end
    end
    if (te < 0) begin
      n_mismatch++;
      print_verdict();
    end
    chk("stateLatency", 32'(eL), 32'(ts - t0));
    chk("stateCycles", 32'(eD), 32'(te - ts));
    chk("rttOhms", {24'h0, eO}, {24'h0, oh});
    chk("driveEnable", {31'h0, sel == 2}, {31'h0, de});
  endtask

  initial begin
    n_mismatch = 0;
    check_count = 0;
    {regAddr, regWrData, regWrite, regRead, selfRefresh} = '0;
    {wantPin, wantWrite, wantRead, wantChop, shortPin} = '0;
    holdNeed = 4'h6;
    dllLocked = 1'b1;
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // Settled idle states for each code pair and pin level
    foreach (IDLE[i]) begin
      wr(4'h0, {24'h0, IDLE[i].term});
      wantPin <= IDLE[i].pin;
      repeat (20) @(posedge clock);
      @(negedge clock);
      chk("termState", {27'h0, IDLE[i].st}, {27'h0, termState});
      chk("rttOhms", {24'h0, IDLE[i].ohm}, {24'h0, rttOhms});
      chk("odtRxEnable", {31'h0, IDLE[i].rx}, {31'h0, odtRxEnable});
    end
    wantPin <= 1'b0;
    $display("test idle done");
    // Reset in mid-run
    @(posedge clock);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("rstState", {27'h0, HIZ}, {27'h0, termState});
    chk("rstOuts", 32'h0, {22'h0, rttOhms, driveEnable, odtRxEnable});
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0000_0009);
    $display("test reset done");
    // Latency windows for every preamble, CRC and burst setup, with and without parity
    wr(4'h0, 32'h0000_0121);
    foreach (CFG[i]) begin
      wr(4'h4, CFG[i].lat);
      holdNeed <= CFG[i].hold;
      wantChop <= CFG[i].chop;
      repeat (4) @(posedge clock);
      win(0, 1'b0, 0, NOM, CFG[i].lt, CFG[i].hold, 8'h3C);
      win(1, 1'b0, 0, WRT, CFG[i].lt, CFG[i].wr, 8'h78);
      win(2, 1'b0, 0, DRV, CFG[i].lt, CFG[i].rd, 8'h00);
    end
    $display("test latency done");
    // Priority over the pin and back-to-back writes
    wr(4'h4, 32'h0000_0009);
    holdNeed <= 4'h6;
    wantChop <= 1'b0;
    win(1, 1'b1, 0, WRT, 7, 6, 8'h78);
    win(2, 1'b1, 0, DRV, 7, 6, 8'h00);
    win(1, 1'b0, 2, WRT, 7, 8, 8'h78);
    $display("test priority done");
    // Zero write code: a write must leave the parked state alone
    wr(4'h0, 32'h0000_0021);
    @(posedge clock);
    wantWrite <= 1'b1;
    @(posedge clock);
    wantWrite <= 1'b0;
    repeat (10) @(negedge clock);
    chk("noWriteTerm", {27'h0, PRK}, {27'h0, termState});
    // Self-refresh forces high impedance and ignores the pin
    @(posedge clock);
    wantPin <= 1'b1;
    selfRefresh <= 1'b1;
    repeat (20) @(posedge clock);
    @(negedge clock);
    chk("srState", {27'h0, HIZ}, {27'h0, termState});
    chk("srRx", 32'h0, {31'h0, odtRxEnable});
    @(posedge clock);
    wantPin <= 1'b0;
    selfRefresh <= 1'b0;
    repeat (20) @(posedge clock);
    $display("test self refresh done");
    // Short pin pulse raises the sticky hold flag; write one clears it
    shortPin <= 1'b1;
    win(0, 1'b0, 0, NOM, 7, 1, 8'h3C);
    @(posedge clock);
    shortPin <= 1'b0;
    dllLocked <= 1'b0;
    win(0, 1'b0, 0, NOM, 1, 6, 8'h3C);
    rd(4'h8, 32'h0000_0502);
    wr(4'h8, 32'h0000_0100);
    repeat (8) @(posedge clock);
    dllLocked <= 1'b1;
    rd(4'h8, 32'h0000_0602);
    // Unmapped place and full-field write back
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'hC, 32'h0);
    rd(4'h0, 32'h0000_0021);
    wr(4'h0, 32'h0000_0377);
    rd(4'h0, 32'h0000_0377);
    $display("test status done");
    print_verdict();
  end
endmodule
`default_nettype wire
